// ---- hdl/rsm_consts.svh ----
// Summary of operation
// - Boot option picks undervoltage or pin reset
// - Four sources: power-on, pin, watchdog, undervoltage
// - Reset pin filtered then synchronised to clock
// - Any reset loads every control register default
// - Drive reset pin low during reset
// - Unrefreshed watchdog overflow causes system reset
// - Hold reset while supply below reference
// - Pattern 1010B in upper nibble disables watchdog
// - Control bit 7 enables supply-drop detector
// - Control register selects one of four thresholds
// - Bit 5 flag follows supply-low, self-clearing
// - Enabled supply drop raises interrupt request
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH
`define RSM_ADDR_W        4
`define RSM_OFF_BTCTL     4'h0
`define RSM_OFF_SDCTL     4'h1
`define RSM_OFF_IRQ_STAT  4'h2
`define RSM_OFF_IRQ_MASK  4'h3
`define RSM_OFF_WDT_CLR   4'h4
`define RSM_OFF_RST_CAUSE 4'h5
`define RSM_BTCTL_RST     8'h00
`define RSM_SDCTL_RST     8'h00
`define RSM_WDT_OFF_PAT   4'hA
`define RSM_SD_EN_BIT     7
`define RSM_SD_FLAG_BIT   5
`define RSM_WDT_CLR_KEY   8'hA5
`define RSM_WDT_W         16
`define RSM_RST_STRETCH   8'h10
`endif

// ---- hdl/rsm_pkg.sv ----
`default_nettype none
package rsm_pkg;
	typedef enum logic [2:0] {
		RSM_ST_RESET   = 3'b001,
		RSM_ST_STRETCH = 3'b010,
		RSM_ST_RUN     = 3'b100
	} rsm_state_t;
	typedef logic [1:0] rsm_level_t;
endpackage : rsm_pkg
`default_nettype wire

// ---- hdl/rsm_sync.sv ----
`default_nettype none
// Two-stage synchroniser, resets to a chosen level
module rsm_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);
	logic meta_reg;
	// First stage feeds only the second
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= INIT;
			q        <= INIT;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : rsm_sync
`default_nettype wire

// ---- hdl/rsm_wdt.sv ----
`default_nettype none
`include "rsm_consts.svh"
// Watchdog counter, one-cycle overflow pulse
module rsm_wdt (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic refresh,
	output logic      overflow
);
	logic [`RSM_WDT_W-1:0] cnt_reg;
	// Counter restarts on refresh or when disabled
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg  <= '0;
			overflow <= 1'b0;
		end
		else
		begin
			overflow <= 1'b0;
			if (!enable || refresh)
				cnt_reg <= '0;
			else if (&cnt_reg)
			begin
				cnt_reg  <= '0;
				overflow <= 1'b1;
			end
			else
				cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : rsm_wdt
`default_nettype wire

// ---- hdl/rsm_top.sv ----
`default_nettype none
`include "rsm_consts.svh"
// Reset merge and supply monitor
module rsm_top (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   boot_use_uv_reset,
	input  wire logic                   external_reset_in_n,
	input  wire logic                   uv_below_ref,
	input  wire logic [3:0]             supply_below_level,
	input  wire logic [`RSM_ADDR_W-1:0] addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [7:0]             rdata,
	output logic                        external_reset_pin_out,
	output logic                        external_reset_pin_oe,
	output logic                        sys_reset,
	output logic                        irq,
	output logic      [1:0]             detect_threshold
);
	logic              pin_n_sync;
	logic              uv_sync;
	logic [3:0]        sd_sync;
	logic              wdt_ovf;
	logic              sys_rst_int;
	logic [7:0]        btctl_reg;
	logic [7:0]        sdctl_reg;
	logic [1:0]        irq_stat_reg;
	logic [1:0]        irq_mask_reg;
	logic [3:0]        cause_reg;
	logic              wdt_refresh;
	logic              sd_low;
	logic              sd_low_d_reg;
	logic              pin_src;
	logic              uv_src;
	logic              hold;
	logic              drive_now;
	logic [2:0]        echo_reg;
	logic              srst_m_reg;
	logic              srst_reg;
	logic [7:0]        stretch_reg;
	rsm_pkg::rsm_state_t state_reg;
	rsm_pkg::rsm_state_t state_next;

	// Register write decode, shared by several processes
	function automatic logic hit(input logic [`RSM_ADDR_W-1:0] a,
		input logic [`RSM_ADDR_W-1:0] off);
		hit = wr && (a == off);
	endfunction : hit

	// Pin level passes a Schmitt pad, then two flops
	rsm_sync #(.INIT(1'b0)) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   (external_reset_in_n),
		.q   (pin_n_sync)
	);
	rsm_sync #(.INIT(1'b1)) u_uv_sync (
		.clk (clk),
		.rst (rst),
		.d   (uv_below_ref),
		.q   (uv_sync)
	);
	// One synchroniser per threshold comparator
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sd
			rsm_sync #(.INIT(1'b0)) u_sd_sync (
				.clk (clk),
				.rst (rst),
				.d   (supply_below_level[gi]),
				.q   (sd_sync[gi])
			);
		end
	endgenerate

	// Own pin drive reads back low; masked until the synchroniser drains
	assign drive_now = !external_reset_pin_oe;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			echo_reg <= 3'h7;
		else
			echo_reg <= {echo_reg[1:0], drive_now};
	end

	// Boot option selects which external source is live
	assign pin_src = !boot_use_uv_reset && !pin_n_sync && !drive_now && !(|echo_reg);
	assign uv_src  = boot_use_uv_reset && uv_sync;
	assign hold    = pin_src || uv_src || wdt_ovf;

	// Stretch state machine keeps reset long enough to be seen
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			rsm_pkg::RSM_ST_RESET:
				if (!hold)
					state_next = rsm_pkg::RSM_ST_STRETCH;
			rsm_pkg::RSM_ST_STRETCH:
				if (hold)
					state_next = rsm_pkg::RSM_ST_RESET;
				else if (stretch_reg == `RSM_RST_STRETCH)
					state_next = rsm_pkg::RSM_ST_RUN;
			rsm_pkg::RSM_ST_RUN:
				if (hold)
					state_next = rsm_pkg::RSM_ST_RESET;
			default:
				state_next = rsm_pkg::RSM_ST_RESET;
		endcase
	end

	// State and stretch counter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg   <= rsm_pkg::RSM_ST_RESET;
			stretch_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == rsm_pkg::RSM_ST_STRETCH && !hold)
				stretch_reg <= stretch_reg + 8'h01;
			else
				stretch_reg <= 8'h00;
		end
	end

	// Internal reset: async assert, sync release via two flops
	assign sys_rst_int = rst || (state_reg != rsm_pkg::RSM_ST_RUN);
	always_ff @(posedge clk or posedge sys_rst_int)
	begin
		if (sys_rst_int)
		begin
			srst_m_reg <= 1'b1;
			srst_reg   <= 1'b1;
		end
		else
		begin
			srst_m_reg <= 1'b0;
			srst_reg   <= srst_m_reg;
		end
	end

	// Outputs are flopped copies; pin pulled low while in reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sys_reset              <= 1'b1;
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe  <= 1'b0;
		end
		else
		begin
			sys_reset              <= srst_reg;
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe  <= !srst_reg;
		end
	end

	// Watchdog runs unless the off pattern is loaded
	assign wdt_refresh = hit(addr, `RSM_OFF_WDT_CLR) && wdata == `RSM_WDT_CLR_KEY;
	rsm_wdt u_wdt (
		.clk      (clk),
		.rst      (srst_reg),
		.enable   (btctl_reg[7:4] != `RSM_WDT_OFF_PAT),
		.refresh  (wdt_refresh),
		.overflow (wdt_ovf)
	);

	// Control registers return to defaults on any system reset
	always_ff @(posedge clk or posedge srst_reg)
	begin
		if (srst_reg)
		begin
			btctl_reg    <= `RSM_BTCTL_RST;
			sdctl_reg    <= `RSM_SDCTL_RST;
			irq_mask_reg <= 2'h0;
		end
		else
		begin
			// Stabilisation field is only stored; software owns timing
			if (hit(addr, `RSM_OFF_BTCTL))
				btctl_reg <= wdata;
			if (hit(addr, `RSM_OFF_SDCTL))
				sdctl_reg <= {wdata[7], 5'h00, wdata[1:0]};
			if (hit(addr, `RSM_OFF_IRQ_MASK))
				irq_mask_reg <= wdata[1:0];
		end
	end

	// Selected comparator, gated by enable
	assign sd_low = sdctl_reg[`RSM_SD_EN_BIT] && sd_sync[sdctl_reg[1:0]];

	// Sticky events: set wins over write-one-to-clear
	always_ff @(posedge clk or posedge srst_reg)
	begin
		if (srst_reg)
		begin
			sd_low_d_reg <= 1'b0;
			irq_stat_reg <= 2'h0;
		end
		else
		begin
			sd_low_d_reg <= sd_low;
			for (int i = 0; i < 2; i++)
			begin
				if (i == 0 && sd_low && !sd_low_d_reg)
					irq_stat_reg[i] <= 1'b1;
				else if (i == 1 && wdt_ovf)
					irq_stat_reg[i] <= 1'b1;
				else if (hit(addr, `RSM_OFF_IRQ_STAT) && wdata[i])
					irq_stat_reg[i] <= 1'b0;
			end
		end
	end

	// Cause register survives system reset; power-on loads 1, writing ones clears bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cause_reg <= 4'h1;
		else if (pin_src || uv_src || wdt_ovf)
			cause_reg <= cause_reg | {uv_src, wdt_ovf, pin_src, 1'b0};
		else if (hit(addr, `RSM_OFF_RST_CAUSE))
			cause_reg <= cause_reg & ~wdata[3:0];
	end

	// Interrupt, threshold output and read data
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq              <= 1'b0;
			detect_threshold <= 2'h0;
			rdata            <= 8'h00;
		end
		else
		begin
			irq              <= |(irq_stat_reg & irq_mask_reg);
			detect_threshold <= sdctl_reg[1:0];
			rdata            <= 8'h00;
			if (rd)
			begin
				unique case (addr)
					`RSM_OFF_BTCTL:     rdata <= btctl_reg;
					`RSM_OFF_SDCTL:     rdata <= {sdctl_reg[7], 1'b0, sd_low, 3'h0,
						sdctl_reg[1:0]};
					`RSM_OFF_IRQ_STAT:  rdata <= {6'h00, irq_stat_reg};
					`RSM_OFF_IRQ_MASK:  rdata <= {6'h00, irq_mask_reg};
					`RSM_OFF_RST_CAUSE: rdata <= {4'h0, cause_reg};
					default:            rdata <= 8'h00;
				endcase
			end
		end
	end

	// Pin driven low whenever system reset holds
	property p_pin_low;
		@(posedge clk) disable iff (rst) srst_reg |=> external_reset_pin_oe == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin not driven in reset");

	property p_wdt_reset;
		@(posedge clk) disable iff (rst) wdt_ovf |=> state_reg == rsm_pkg::RSM_ST_RESET;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog missed reset");

	property p_uv_hold;
		@(posedge clk) disable iff (rst) uv_src |=> ##2 srst_reg;
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("undervoltage did not hold");

	property p_wdt_off;
		@(posedge clk) disable iff (rst) btctl_reg[7:4] == `RSM_WDT_OFF_PAT |-> !wdt_ovf;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog not disabled");

	property p_flag_en;
		@(posedge clk) disable iff (rst) !sdctl_reg[`RSM_SD_EN_BIT] |-> !sd_low;
	endproperty
	a_flag_en: assert property (p_flag_en) else $error("detector active while off");

	property p_irq_set;
		@(posedge clk) disable iff (rst || srst_reg)
			$rose(sd_low) |=> irq_stat_reg[0];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("drop event lost");

	property p_irq_out;
		@(posedge clk) disable iff (rst)
			(|(irq_stat_reg & irq_mask_reg)) |=> irq;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

	property p_release;
		@(posedge clk) disable iff (rst)
			$fell(srst_reg) |-> $past(state_reg, 2) == rsm_pkg::RSM_ST_RUN;
	endproperty
	a_release: assert property (p_release) else $error("early reset release");

	property p_pin_src;
		@(posedge clk) disable iff (rst) pin_src |=> !(state_reg == rsm_pkg::RSM_ST_RUN);
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("pin reset ignored");

	// Source masking, defaults, cause capture and release order
	property p_drive_mask;
		@(posedge clk) disable iff (rst) !external_reset_pin_oe |-> !pin_src;
	endproperty
	a_drive_mask: assert property (p_drive_mask) else $error("own drive seen as reset");

	property p_pin_sync;
		@(posedge clk) disable iff (rst) pin_src |-> !$past(external_reset_in_n, 2);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin reset not synchronised");

	property p_cause_wdt;
		@(posedge clk) disable iff (rst) wdt_ovf |=> cause_reg[2];
	endproperty
	a_cause_wdt: assert property (p_cause_wdt) else $error("watchdog cause lost");

	property p_ctrl_default;
		@(posedge clk) disable iff (rst)
			srst_reg |-> btctl_reg == `RSM_BTCTL_RST && sdctl_reg == `RSM_SDCTL_RST;
	endproperty
	a_ctrl_default: assert property (p_ctrl_default) else $error("register not at default");

	property p_stretch_run;
		@(posedge clk) disable iff (rst)
			state_reg == rsm_pkg::RSM_ST_STRETCH && stretch_reg == `RSM_RST_STRETCH && !hold
			|=> state_reg == rsm_pkg::RSM_ST_RUN;
	endproperty
	a_stretch_run: assert property (p_stretch_run) else $error("release not taken");

	property p_threshold;
		@(posedge clk) disable iff (rst) 1'b1 |=> detect_threshold == $past(sdctl_reg[1:0]);
	endproperty
	a_threshold: assert property (p_threshold) else $error("threshold output wrong");

	property p_sys_out;
		@(posedge clk) disable iff (rst) srst_reg |=> sys_reset;
	endproperty
	a_sys_out: assert property (p_sys_out) else $error("system reset output low");

	property p_flag_read;
		@(posedge clk) disable iff (rst) rd && addr == `RSM_OFF_SDCTL
			|=> rdata[`RSM_SD_FLAG_BIT] == $past(sd_low);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("supply flag misread");
endmodule : rsm_top
`default_nettype wire

// ---- tb/rsm_pin_model.sv ----
`default_nettype none
// Reset pin pad: pull-up, push button and device both pull low
module rsm_pin_model (
	input  wire logic pin_out,
	input  wire logic drive_en_n,
	input  wire logic press_n,
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// Wired low; pull-up only when nobody pulls, so no stale level
	assign pin_level = (drive_en_n | pin_out) & press_n;
endmodule : rsm_pin_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst, boot, pin_n, uv, wr, rd, press_n;
	logic       pin_out, pin_oe, sys_reset, irq;
	logic [3:0] below, addr;
	logic [7:0] wdata, rdata, rv;
	logic [1:0] thr;
	int         failures, cmp_count, n;

	rsm_top uut (.clk(clk), .rst(rst), .boot_use_uv_reset(boot), .external_reset_in_n(pin_n),
		.uv_below_ref(uv), .supply_below_level(below), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .external_reset_pin_out(pin_out),
		.external_reset_pin_oe(pin_oe), .sys_reset(sys_reset), .irq(irq),
		.detect_threshold(thr));
	rsm_pin_model pad (.pin_out(pin_out), .drive_en_n(pin_oe), .press_n(press_n),
		.pin_level(pin_n));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Leading edge wait keeps strobes from being driven twice at one edge
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : rd_reg

	// Bounded wait for the system reset level, cycles waited in n
	task automatic wait_rst(input logic lvl, input int lim);
		n = 0;
		while (sys_reset !== lvl && n < lim)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk({7'h00, sys_reset}, {7'h00, lvl});
	endtask : wait_rst

	task automatic t_reset;
		repeat (20) @(posedge clk);
		chk({6'h00, sys_reset, pin_oe}, 8'h02);
		rst <= 1'b0;
		wait_rst(1'b0, 200);
		rd_reg(4'h5);
		chk(rv, 8'h01);
		wr_reg(4'h5, 8'h01);
		rd_reg(4'h0);
		chk(rv, 8'h00);
		rd_reg(4'hF);
		chk(rv, 8'h00);
	endtask : t_reset

	task automatic t_detect;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(4'h1, 8'h80 | 8'(i));
			below <= 4'h1 << i;
			repeat (5) @(posedge clk);
			rd_reg(4'h1);
			chk(rv, 8'hA0 | 8'(i));
			chk({6'h00, thr}, 8'(i));
			below <= ~(4'h1 << i);
			repeat (5) @(posedge clk);
			rd_reg(4'h1);
			chk(rv, 8'h80 | 8'(i));
		end
		wr_reg(4'h3, 8'h01);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h01);
		wr_reg(4'h2, 8'h01);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		below <= 4'hF;
		wr_reg(4'h1, 8'h03);
		repeat (5) @(posedge clk);
		rd_reg(4'h1);
		chk(rv, 8'h03);
		chk({7'h00, irq}, 8'h00);
		below <= 4'h0;
	endtask : t_detect

	task automatic t_pin;
		wr_reg(4'h1, 8'h81);
		press_n <= 1'b0;
		wait_rst(1'b1, 10);
		chk({7'h00, pin_oe}, 8'h00);
		repeat (10) @(posedge clk);
		press_n <= 1'b1;
		wait_rst(1'b0, 200);
		rd_reg(4'h1);
		chk(rv, 8'h00);
		rd_reg(4'h5);
		chk(rv, 8'h02);
		wr_reg(4'h5, 8'h02);
	endtask : t_pin

	task automatic t_uv;
		boot <= 1'b1;
		press_n <= 1'b0;
		repeat (20) @(posedge clk);
		chk({7'h00, sys_reset}, 8'h00);
		press_n <= 1'b1;
		uv <= 1'b1;
		wait_rst(1'b1, 10);
		repeat (60) @(posedge clk);
		chk({7'h00, sys_reset}, 8'h01);
		uv <= 1'b0;
		wait_rst(1'b0, 200);
		rd_reg(4'h5);
		chk(rv, 8'h08);
		wr_reg(4'h5, 8'h08);
	endtask : t_uv

	// A disable gap must push overflow a full span past re-enable
	task automatic t_wdt;
		wr_reg(4'h4, 8'hA5);
		repeat (2000) @(posedge clk);
		wr_reg(4'h0, 8'hA3);
		repeat (1000) @(posedge clk);
		rd_reg(4'h5);
		chk(rv, 8'h00);
		rd_reg(4'h0);
		chk(rv, 8'hA3);
		wr_reg(4'h0, 8'h00);
		wait_rst(1'b1, 66000);
		chk(8'(n > 65000), 8'h01);
		chk(8'(n < 65600), 8'h01);
		wait_rst(1'b0, 200);
		rd_reg(4'h5);
		chk(rv, 8'h04);
	endtask : t_wdt

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard sized above the single watchdog span
	initial
	begin
		repeat (90000) @(posedge clk);
		failures++;
		stop_test();
	end

	initial
	begin
		rst = 1'b1;
		boot = 1'b0;
		uv = 1'b0;
		press_n = 1'b1;
		below = 4'h0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		failures = 0;
		cmp_count = 0;
		t_reset();
		t_detect();
		t_pin();
		t_uv();
		t_wdt();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
